// File: rtl/rsps_sequencer.sv
// Operation
// - Three-phase: master pulses rotate phases 1-2-3
// - Two-phase: master pulses alternate phases 1-2
// - Single-phase: every master pulse clocks phase 1
// - Ramp reaching compensation emits pulse, restarts ramp
// - Phase pulse on clock, off at window
// - Diode emulation: zero crossing kills low-side drive
// - Phase with sense strap high is unused
// - Phase-one strap high disables whole output
// - Start only after enable seen high
// - Enable latches boot code as targets
// - Wait 8 ms, reading straps meanwhile
// - Straps decode driver, frequency, slew, offset
// - Step code from zero up to target
// - Step rate follows strap-selected slew rate
// - Power good when ramp reaches target
// - Commands accepted only after host power ok
// - Transition flag only for rising changes
// - Telemetry shifted out after transition completes
// - Earlier comparator trip gives earlier pulses
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rsps_sequencer
  import rsps_pkg::*;
#(
  parameter int STARTUP_DELAY_CYC = START_DELAY_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic serial_vid_clock_i,
  input wire logic serial_vid_data_i,
  input wire logic host_power_ok_i,
  input wire logic core_ramp_at_comp_i,
  input wire logic aux_ramp_at_comp_i,
  input wire logic [NPH-1:0] window_level_reached_i,
  input wire logic [NPH-1:0] zero_cross_i,
  input wire logic [2:0] per_phase_sense_strap_i,
  input wire logic aux_output_phase1_sense_strap_i,
  input wire logic aux_output_phase2_sense_strap_i,
  input wire logic [2:0] core_compensation_strap_i,
  input wire logic [1:0] aux_compensation_level_strap_i,
  input wire logic slew_rate_strap_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic master_clock_o,
  output logic aux_master_clock_o,
  output logic [NPH-1:0] phase_pulse_o,
  output logic [NPH-1:0] low_side_gate_drive_o,
  output logic core_power_good_o,
  output logic aux_power_good_o,
  output logic transition_complete_flag_o,
  output logic telemetry_data_o,
  output logic [7:0] core_vid_code_o,
  output logic [7:0] aux_vid_code_o,
  output logic driver_assign_o,
  output logic [1:0] switching_freq_sel_o,
  output logic [1:0] offset_sel_o
);

  function automatic logic [7:0] boot_code(input logic clk_lvl, input logic dat_lvl);
    case ({clk_lvl, dat_lvl})
      2'b00: boot_code = BOOT_CODE_0;
      2'b01: boot_code = BOOT_CODE_1;
      2'b10: boot_code = BOOT_CODE_2;
      default: boot_code = BOOT_CODE_3;
    endcase
  endfunction : boot_code

  function automatic logic [1:0] next_ptr(input logic [1:0] ptr, input logic [1:0] cnt);
    next_ptr = (2'(ptr + 2'h1) >= cnt) ? PH1 : 2'(ptr + 2'h1);
  endfunction : next_ptr

  function automatic logic [7:0] step_toward(input logic [7:0] code, input logic [7:0] tgt);
    if (code < tgt) begin
      step_toward = 8'(code + 8'h01);
    end else if (code > tgt) begin
      step_toward = 8'(code - 8'h01);
    end else begin
      step_toward = code;
    end
  endfunction : step_toward

  // Three-stage synchroniser; a level counts once stages two and three agree
  logic [SYN_W-1:0] s1, s2, s3, sv;
  wire [SYN_W-1:0] raw = {slew_rate_strap_i, aux_compensation_level_strap_i,
                          core_compensation_strap_i, aux_output_phase2_sense_strap_i,
                          aux_output_phase1_sense_strap_i, per_phase_sense_strap_i,
                          zero_cross_i, window_level_reached_i, aux_ramp_at_comp_i,
                          core_ramp_at_comp_i, host_power_ok_i, serial_vid_data_i,
                          serial_vid_clock_i, enable_i};
  wire [SYN_W-1:0] agree = ~(s2 ^ s3);
  wire [SYN_W-1:0] next_sv = (agree & s3) | (~agree & sv);
  wire [SYN_W-1:0] rise = agree & s3 & ~sv;
  wire [SYN_W-1:0] fall = agree & ~s3 & sv;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      sv <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      sv <= next_sv;
    end
  end

  wire en = sv[IX_EN];
  wire svc_rise = rise[IX_SVC];
  wire svc_fall = fall[IX_SVC];
  wire serial_vid_data = sv[IX_SVD];
  wire [NPH-1:0] win_rise = rise[IX_WIN +: NPH];
  wire [NPH-1:0] zc_rise = rise[IX_ZC +: NPH];

  rsps_state_t state, next_state;
  logic [DLY_W-1:0] dly_cnt;
  logic [4:0] strap_q;
  logic [5:0] cfg_q;
  logic [7:0] core_code, aux_code, core_tgt, aux_tgt;
  logic core_pg, aux_pg;
  logic [7:0] step_cnt;
  logic [1:0] ctrl;

  wire dly_done = dly_cnt == DLY_W'(STARTUP_DELAY_CYC - 1);
  wire running = (state == ST_RAMP) || (state == ST_RUN);
  wire core_at = core_code == core_tgt;
  wire aux_at = aux_code == aux_tgt;

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (en) begin
          next_state = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          next_state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (core_at && aux_at) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
    if (!en) begin
      next_state = ST_OFF;
    end
  end

  wire [DLY_W-1:0] next_dly = (state == ST_DELAY) ? DLY_W'(dly_cnt + 1'b1) : '0;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= ST_OFF;
      dly_cnt <= '0;
    end else begin
      state <= next_state;
      dly_cnt <= next_dly;
    end
  end

  // Straps are read continuously through the delay and frozen afterwards
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      strap_q <= '0;
      cfg_q <= '0;
    end else if (state == ST_DELAY) begin
      strap_q <= sv[IX_STRAP +: 5];
      cfg_q <= sv[IX_CFG +: 6];
    end
  end

  assign driver_assign_o = cfg_q[2];
  assign switching_freq_sel_o = cfg_q[1:0];
  assign offset_sel_o = cfg_q[4:3];
  wire slew_fast = cfg_q[5];

  // Phase usage from the sense straps
  wire core_off = strap_q[ST_C1];
  wire aux_off = strap_q[ST_A1];
  wire [1:0] core_cnt = strap_q[ST_C2] ? CNT1 : (strap_q[ST_C3] ? CNT2 : CNT3);
  wire [1:0] aux_cnt = strap_q[ST_A2] ? CNT1 : CNT2;
  wire [NPH-1:0] used = {~aux_off & (aux_cnt == CNT2), ~aux_off,
                         ~core_off & (core_cnt == CNT3), ~core_off & (core_cnt != CNT1),
                         ~core_off};

  // Master clock: a one-shot at each trip of the ramp comparator, which also restarts the ramp.
  // A rising compensation level trips the comparator sooner, so pulses come earlier.
  logic mclk, amclk;
  logic [1:0] cptr, aptr;
  wire next_mclk = running & ~core_off & rise[IX_CRAMP];
  wire next_amclk = running & ~aux_off & rise[IX_ARAMP];
  wire [1:0] next_cptr = (state == ST_OFF) ? PH1 : (mclk ? next_ptr(cptr, core_cnt) : cptr);
  wire [1:0] next_aptr = (state == ST_OFF) ? PH1 : (amclk ? next_ptr(aptr, aux_cnt) : aptr);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mclk <= 1'b0;
      amclk <= 1'b0;
      cptr <= PH1;
      aptr <= PH1;
    end else begin
      mclk <= next_mclk;
      amclk <= next_amclk;
      cptr <= next_cptr;
      aptr <= next_aptr;
    end
  end

  assign master_clock_o = mclk;
  assign aux_master_clock_o = amclk;

  // Phase clocks; the pointer never reaches an unused phase
  wire [NPH-1:0] pclk = {amclk & (aptr == PH2), amclk & (aptr == PH1),
                         mclk & (cptr == PH3), mclk & (cptr == PH2),
                         mclk & (cptr == PH1)};

  // Pulse and low-side drive; a clock outranks a window trip in the same cycle
  logic [NPH-1:0] pulse, low_side_gate_drive, block;
  wire de = ctrl[CTRL_DE];
  wire [NPH-1:0] run_v = {NPH{running}};
  wire [NPH-1:0] next_pulse = run_v & (pclk | (pulse & ~win_rise));
  wire [NPH-1:0] next_block = run_v & {NPH{de}} & ~pclk & (block | zc_rise);
  wire [NPH-1:0] next_low_side_gate_drive = run_v & used & ~next_pulse & ~next_block;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pulse <= '0;
      block <= '0;
      low_side_gate_drive <= '0;
    end else begin
      pulse <= next_pulse;
      block <= next_block;
      low_side_gate_drive <= next_low_side_gate_drive;
    end
  end

  assign phase_pulse_o = pulse;
  assign low_side_gate_drive_o = low_side_gate_drive;

  // Serial command receiver: one select bit then eight code bits, MSB first
  logic [3:0] rx_cnt;
  logic [7:0] rx_sh;
  logic up_c, up_a, vt_flag;
  wire run_ok = (state == ST_RUN) && sv[IX_POK];
  wire cmd_done = run_ok && svc_rise && (rx_cnt == RX_LAST);
  wire [7:0] new_code = {rx_sh[6:0], serial_vid_data};
  wire cmd_c = cmd_done && !rx_sh[7];
  wire cmd_a = cmd_done && rx_sh[7];
  wire [3:0] next_rx_cnt = !run_ok ? 4'h0 : (!svc_rise ? rx_cnt :
                           (cmd_done ? 4'h0 : 4'(rx_cnt + 4'h1)));
  wire [7:0] next_rx_sh = (run_ok && svc_rise) ? {rx_sh[6:0], serial_vid_data} : rx_sh;
  wire next_up_c = (state == ST_OFF) ? 1'b0 : (cmd_c ? (new_code > core_code) : (up_c & ~core_at));
  wire next_up_a = (state == ST_OFF) ? 1'b0 : (cmd_a ? (new_code > aux_code) : (up_a & ~aux_at));
  wire next_vt = (up_c & core_at & ~cmd_c) | (up_a & aux_at & ~cmd_a);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_cnt <= 4'h0;
      rx_sh <= 8'h00;
      up_c <= 1'b0;
      up_a <= 1'b0;
      vt_flag <= 1'b0;
    end else begin
      rx_cnt <= next_rx_cnt;
      rx_sh <= next_rx_sh;
      up_c <= next_up_c;
      up_a <= next_up_a;
      vt_flag <= next_vt;
    end
  end

  assign transition_complete_flag_o = vt_flag;

  // Digital soft-start and slew: one code step per step interval
  wire [7:0] step_len = slew_fast ? STEP_FAST_CYC : STEP_SLOW_CYC;
  wire step_tick = running && (step_cnt == 8'(step_len - 8'h01));
  wire [7:0] next_step_cnt = (!running || step_tick) ? 8'h00 : 8'(step_cnt + 8'h01);
  wire latch_boot = (state == ST_OFF) && en;
  wire [7:0] boot_sel = boot_code(sv[IX_SVC], serial_vid_data);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      step_cnt <= 8'h00;
      core_code <= 8'h00;
      aux_code <= 8'h00;
      core_tgt <= 8'h00;
      aux_tgt <= 8'h00;
      core_pg <= 1'b0;
      aux_pg <= 1'b0;
    end else begin
      step_cnt <= next_step_cnt;
      if (state == ST_OFF) begin
        core_code <= 8'h00;
        aux_code <= 8'h00;
        core_pg <= 1'b0;
        aux_pg <= 1'b0;
      end else if (step_tick) begin
        core_code <= step_toward(core_code, core_tgt);
        aux_code <= step_toward(aux_code, aux_tgt);
      end
      if (state == ST_RAMP && core_at) begin
        core_pg <= 1'b1;
      end
      if (state == ST_RAMP && aux_at) begin
        aux_pg <= 1'b1;
      end
      if (latch_boot) begin
        core_tgt <= boot_sel;
        aux_tgt <= boot_sel;
      end else begin
        if (cmd_c) begin
          core_tgt <= new_code;
        end
        if (cmd_a) begin
          aux_tgt <= new_code;
        end
      end
    end
  end

  assign core_power_good_o = core_pg;
  assign aux_power_good_o = aux_pg;
  assign core_vid_code_o = core_code;
  assign aux_vid_code_o = aux_code;

  // Telemetry: codes shifted MSB first on host clock falling edges
  logic [3:0] tel_cnt;
  logic [15:0] tel_sh;
  wire tel_on = run_ok && ctrl[CTRL_TEL] && !up_c && !up_a && core_at && aux_at;
  wire [15:0] tel_word = {core_code, aux_code};
  wire [15:0] next_tel_sh = !tel_on ? tel_word : (!svc_fall ? tel_sh :
                            ((tel_cnt == TEL_LAST) ? tel_word : {tel_sh[14:0], 1'b0}));
  wire [3:0] next_tel_cnt = !tel_on ? 4'h0 : (svc_fall ? 4'(tel_cnt + 4'h1) : tel_cnt);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tel_cnt <= 4'h0;
      tel_sh <= 16'h0000;
    end else begin
      tel_cnt <= next_tel_cnt;
      tel_sh <= next_tel_sh;
    end
  end

  assign telemetry_data_o = tel_sh[15];

  // Register port; unmapped addresses read zero
  wire sel_ctrl = reg_addr_i == REG_CTRL;
  wire sel_status = reg_addr_i == REG_STATUS;
  wire sel_codes = reg_addr_i == REG_CODES;
  wire [31:0] rd_mux = sel_ctrl ? {30'h0, ctrl} :
                       sel_status ? {26'h0, aux_off, core_off, aux_pg, core_pg, state} :
                       sel_codes ? {aux_tgt, core_tgt, aux_code, core_code} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl <= 2'h0;
      reg_rdata_o <= 32'h0;
    end else begin
      if (reg_we_i && sel_ctrl) begin
        ctrl <= reg_wdata_i[1:0];
      end
      reg_rdata_o <= reg_re_i ? rd_mux : 32'h0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_THREE_ROTATE: assert property (
    mclk && core_cnt == CNT3 && cptr == PH3 |=> cptr == PH1)
    else $error("three-phase rotation broken");
  AST_TWO_ALTERNATE: assert property (
    mclk && core_cnt == CNT2 |-> !pclk[2] ##1 cptr != $past(cptr))
    else $error("two-phase alternation broken");
  AST_ONE_PHASE: assert property (
    core_cnt == CNT1 |-> pclk[2:1] == 2'b00 && pclk[0] == mclk)
    else $error("single-phase clock not on phase one");
  AST_MCLK_ON_RAMP: assert property (
    running && !core_off && rise[IX_CRAMP] && next_state != ST_OFF |=> mclk)
    else $error("ramp trip gave no master pulse");
  AST_PULSE_ON: assert property (
    pclk[0] && running |=> pulse[0])
    else $error("phase clock did not raise pulse");
  AST_PULSE_OFF: assert property (
    pulse[0] && win_rise[0] && !pclk[0] |=> !pulse[0])
    else $error("window trip did not end pulse");
  AST_DE_NO_REVERSE: assert property (
    de && running && zc_rise[1] && !pclk[1] |=> !low_side_gate_drive[1])
    else $error("low side left on after zero crossing");
  AST_UNUSED_QUIET: assert property (
    !used[2] && !$past(used[2]) |-> !pclk[2] && !pulse[2])
    else $error("unused phase was clocked");
  AST_OUTPUT_OFF: assert property (
    core_off && $past(core_off) |-> !mclk && pulse[2:0] == 3'b000)
    else $error("disabled output still switching");
  AST_BOOT_LATCH: assert property (
    latch_boot |=> core_tgt == $past(boot_sel) && aux_tgt == $past(boot_sel))
    else $error("boot code not latched");
  AST_DELAY_DONE: assert property (
    state == ST_RAMP && $past(state) == ST_DELAY |-> $past(dly_cnt) == DLY_W'(STARTUP_DELAY_CYC - 1))
    else $error("ramp began before start-up delay");
  AST_ONE_STEP: assert property (
    $changed(core_code) && state != ST_OFF && $past(state) != ST_OFF |->
      core_code == 8'($past(core_code) + 8'h01) || core_code == 8'($past(core_code) - 8'h01))
    else $error("code jumped");
  AST_STEP_RATE: assert property (
    $changed(core_code) && state != ST_OFF && $past(state) != ST_OFF |-> $past(step_tick))
    else $error("code stepped off the step tick");
  AST_PG: assert property (
    state == ST_RAMP && core_at |=> core_pg)
    else $error("power good not raised at target");
  AST_NO_EARLY_CMD: assert property (
    !run_ok |-> !cmd_done ##1 $stable(core_tgt) || $past(latch_boot))
    else $error("command taken before power ok");
  AST_TRANSITION_COMPLETE_FLAG_UP: assert property (
    vt_flag |-> $past(up_c) || $past(up_a))
    else $error("transition flag for non-rising change");
  AST_OFF_QUIET: assert property (
    !en |=> state == ST_OFF ##1 pulse == '0)
    else $error("pulses active without enable");
endmodule : rsps_sequencer
`default_nettype wire

// File: rtl/rsps_pkg.sv
package rsps_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 250;
  localparam int CLK_KHZ = 250000;
  localparam int START_DELAY_MS = 8;
  localparam int START_DELAY_CYC = START_DELAY_MS * CLK_KHZ;
  localparam int DLY_W = 21;
  localparam int VID_STEP_UV = 6250;
  localparam int SLEW_FAST_MV_US = 20;
  localparam int SLEW_SLOW_MV_US = 10;
  // Longest step time that still meets the rate, so rounded down
  localparam logic [7:0] STEP_FAST_CYC = 8'(VID_STEP_UV * CLK_MHZ / (SLEW_FAST_MV_US * 1000));
  localparam logic [7:0] STEP_SLOW_CYC = 8'(VID_STEP_UV * CLK_MHZ / (SLEW_SLOW_MV_US * 1000));

  // Boot voltage codes selected by the serial clock and data levels
  localparam logic [7:0] BOOT_CODE_0 = 8'h10;
  localparam logic [7:0] BOOT_CODE_1 = 8'h20;
  localparam logic [7:0] BOOT_CODE_2 = 8'h30;
  localparam logic [7:0] BOOT_CODE_3 = 8'h40;

  // Phase pointer values and phase counts
  localparam logic [1:0] PH1 = 2'h0;
  localparam logic [1:0] PH2 = 2'h1;
  localparam logic [1:0] PH3 = 2'h2;
  localparam logic [1:0] CNT1 = 2'h1;
  localparam logic [1:0] CNT2 = 2'h2;
  localparam logic [1:0] CNT3 = 2'h3;
  localparam int NPH = 5;

  // Synchroniser lanes
  localparam int IX_EN = 0;
  localparam int IX_SVC = 1;
  localparam int IX_SVD = 2;
  localparam int IX_POK = 3;
  localparam int IX_CRAMP = 4;
  localparam int IX_ARAMP = 5;
  localparam int IX_WIN = 6;
  localparam int IX_ZC = 11;
  localparam int IX_STRAP = 16;
  localparam int IX_CFG = 21;
  localparam int SYN_W = 27;

  // Latched strap bits
  localparam int ST_C1 = 0;
  localparam int ST_C2 = 1;
  localparam int ST_C3 = 2;
  localparam int ST_A1 = 3;
  localparam int ST_A2 = 4;

  // Serial frames
  localparam logic [3:0] RX_LAST = 4'h8;
  localparam logic [3:0] TEL_LAST = 4'hf;

  // Register port
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CODES = 4'h8;
  localparam int CTRL_DE = 0;
  localparam int CTRL_TEL = 1;

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_DELAY = 2'b01,
    ST_RAMP = 2'b11,
    ST_RUN = 2'b10
  } rsps_state_t;
endpackage : rsps_pkg

// File: verif/rsps_host.sv
`timescale 1ns/1ps
`default_nettype none
module rsps_host (
  input wire logic core_pg_i,
  input wire logic aux_pg_i,
  output logic svc_o,
  output logic svd_o,
  output logic pok_o
);
  logic allow;
  initial begin
    svc_o = 1'b0;
    svd_o = 1'b0;
    allow = 1'b0;
  end
  // Power ok follows both power goods, so it also drops with them
  assign pok_o = allow & core_pg_i & aux_pg_i;

  // Static levels before enable; caller raises enable afterwards
  task boot(input logic [1:0] c);
    #1;
    svc_o = c[1];
    svd_o = c[0];
  endtask : boot

  // 64 ns frame clock, off-grid start so it is unrelated to the bench clock
  task send(input logic sel, input logic [7:0] code);
    logic [8:0] f;
    f = {sel, code};
    #1.3;
    for (int i = 8; i >= 0; i--) begin
      svd_o = f[i];
      #16;
      svc_o = 1'b1;
      #32;
      svc_o = 1'b0;
      #16;
    end
  endtask : send
endmodule : rsps_host
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rsps_pkg::*;
;
  logic clk_i = 1'b0, reset_i = 1'b1, enable_i = 1'b0, cramp = 1'b0, aramp = 1'b0;
  logic we = 1'b0, re = 1'b0, slew = 1'b0, a2 = 1'b0, re_q = 1'b0;
  logic [4:0] win = 5'h0, zc = 5'h0, pp_q = 5'h0, pp, lsd;
  logic [2:0] strap = 3'h0, ccs = 3'h0;
  logic [1:0] acs = 2'h0, fs, os;
  logic [3:0] addr = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic serial_vid_clock, serial_vid_data, pok, mclk, amclk, cpg, apg, flag, tel, drv;
  logic [7:0] cc, ac, nx;
  int error_cnt = 0, checked = 0, boot;
  int mcn = 0, amn = 0;
  integer seed = 32'hab0e2756;
  logic [31:0] rd_q[$];
  logic [4:0] ph_q[$];
  logic fl_q[$];
  logic [7:0] bt[4] = '{BOOT_CODE_0, BOOT_CODE_1, BOOT_CODE_2, BOOT_CODE_3};
  logic [2:0] sv[4] = '{3'h0, 3'h4, 3'h2, 3'h1};
  int nc[4] = '{3, 2, 1, 0};

  always #2 clk_i = ~clk_i;

  rsps_sequencer #(.STARTUP_DELAY_CYC(20)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i),
    .serial_vid_clock_i(serial_vid_clock), .serial_vid_data_i(serial_vid_data), .host_power_ok_i(pok),
    .core_ramp_at_comp_i(cramp), .aux_ramp_at_comp_i(aramp),
    .window_level_reached_i(win), .zero_cross_i(zc), .per_phase_sense_strap_i(strap),
    .aux_output_phase1_sense_strap_i(1'b0), .aux_output_phase2_sense_strap_i(a2),
    .core_compensation_strap_i(ccs), .aux_compensation_level_strap_i(acs),
    .slew_rate_strap_i(slew), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rdata), .master_clock_o(mclk), .aux_master_clock_o(amclk),
    .phase_pulse_o(pp), .low_side_gate_drive_o(lsd), .core_power_good_o(cpg),
    .aux_power_good_o(apg), .transition_complete_flag_o(flag), .telemetry_data_o(tel),
    .core_vid_code_o(cc), .aux_vid_code_o(ac), .driver_assign_o(drv),
    .switching_freq_sel_o(fs), .offset_sel_o(os)
  );

  rsps_host u_host (.core_pg_i(cpg), .aux_pg_i(apg), .svc_o(serial_vid_clock), .svd_o(serial_vid_data), .pok_o(pok));

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task results;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    re <= 1'b1;
    addr <= a;
    rd_q.push_back(e);
    @(posedge clk_i);
    re <= 1'b0;
  endtask : rd

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    we <= 1'b0;
  endtask : wr

  // Results are paired with the oldest note of their kind
  always @(posedge clk_i) begin
    if (re_q) cmp("rdata", rd_q.pop_front(), rdata);
    if (mclk) mcn++;
    if (amclk) amn++;
    if ((pp & ~pp_q) != 5'h0) begin
      cmp("phase_start", 32'(ph_q.pop_front()), 32'(pp & ~pp_q));
    end
    if (flag) begin
      cmp("flag_expected", 32'h1, 32'(fl_q.size() != 0));
      if (fl_q.size() != 0) fl_q.delete(0);
    end
    re_q <= re;
    pp_q <= pp;
  end

  task pulse;
    @(posedge clk_i);
    cramp <= 1'b1;
    aramp <= 1'b1;
    zc <= 5'($random(seed));
    cyc(4);
    cramp <= 1'b0;
    aramp <= 1'b0;
    cyc(4);
    win <= 5'h1f;
    cyc(4);
    win <= 5'h0;
    cyc(4);
    cmp("pulse_off", 32'h0, 32'(pp));
  endtask : pulse

  task mode(input int m);
    int n, t, ex;
    boot = $random(seed) & 3;
    u_host.boot(2'(boot));
    @(posedge clk_i);
    strap <= sv[m];
    a2 <= (m == 2);
    slew <= ~m[0];
    ccs <= 3'($random(seed));
    acs <= 2'($random(seed));
    cyc(2);
    enable_i <= 1'b1;
    n = 0;
    while (!cpg && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    t = bt[boot] * (m[0] ? STEP_SLOW_CYC : STEP_FAST_CYC);
    cmp("ramp_time", 32'h1, 32'(n >= t && n < t + 60));
    cyc(2);
    rd(REG_CODES, {4{bt[boot]}});
    rd(REG_STATUS, (m == 3) ? 32'h1e : 32'h0e);
    cmp("straps", 32'({acs, ccs}), 32'({os, drv, fs}));
    cmp("dac_codes", 32'({2{bt[boot]}}), 32'({ac, cc}));
    mcn = 0;
    amn = 0;
    for (int i = 0; i < 6; i++) begin
      ex = (nc[m] != 0 ? (1 << (i % nc[m])) : 0) | (8 << (i % (m == 2 ? 1 : 2)));
      ph_q.push_back(5'(ex));
      pulse();
    end
    cmp("master_pulses", 32'({(m == 3) ? 8'h0 : 8'h6, 8'h6}), 32'({8'(mcn), 8'(amn)}));
    $display("mode %0d done", m);
  endtask : mode

  task off;
    @(posedge clk_i);
    enable_i <= 1'b0;
    u_host.allow = 1'b0;
    cyc(8);
    cmp("pulses_off", 32'h0, 32'(pp));
    cmp("pg_off", 32'h0, 32'(cpg));
  endtask : off

  initial begin
    #400000;
    error_cnt++;
    $display("watchdog expired");
    results();
  end

  initial begin
    cyc(10);
    reset_i <= 1'b0;
    cyc(4);
    mode(0);
    nx = bt[boot] + 8'h1 + 8'($random(seed) & 7);
    u_host.send(1'b0, nx);
    cyc(10);
    rd(REG_CODES, {4{bt[boot]}});
    u_host.allow = 1'b1;
    cyc(8);
    fl_q.push_back(1'b1);
    u_host.send(1'b0, nx);
    for (int i = 0; i < 3000 && fl_q.size() != 0; i++) @(posedge clk_i);
    cyc(2);
    rd(REG_CODES, {bt[boot], nx, bt[boot], nx});
    u_host.send(1'b0, bt[boot]);
    cyc(800);
    rd(REG_CODES, {4{bt[boot]}});
    rd(4'hc, 32'h0);
    // Diode emulation: a zero crossing must drop every low side
    zc <= 5'h0;
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, 32'h1);
    cyc(4);
    cmp("low_side_idle", 32'h1f, 32'(lsd));
    zc <= 5'h1f;
    cyc(6);
    cmp("low_side_de", 32'h0, 32'(lsd));
    wr(REG_CTRL, 32'h2);
    cyc(4);
    cmp("low_side_back", 32'h1f, 32'(lsd));
    cmp("telemetry_msb", 32'h0, 32'(tel));
    // Same code again: nine host clock falls shift the telemetry word
    u_host.send(1'b0, bt[boot]);
    cyc(6);
    cmp("telemetry_shift", 32'(bt[boot][6]), 32'(tel));
    wr(REG_CTRL, 32'h0);
    $display("commands done");
    off();
    for (int m = 1; m < 4; m++) begin
      mode(m);
      off();
    end
    cmp("flag_missing", 32'h0, 32'(fl_q.size()));
    results();
  end
endmodule : testbench
`default_nettype wire
